// ===== dv/decoder_tone_ancillary_regs_bench.sv
// Self-checking bench for the tone and ancillary register bank
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module decoder_tone_ancillary_regs_bench;
  import dtr_pkg::*;
  localparam logic [7:0] FW_TB = 8'h3c;  // Arbitrary value
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, sw_rst_i = 1'b0, boot_done_i = 1'b0;
  logic frame_decoded_i = 1'b0, aux_valid_i = 1'b0, aux_frame_end_i = 1'b0, reg_wr_i, reg_rd_i;
  logic [7:0] avg_rate_bits_i = 8'h00, aux_data_i = 8'h00, reg_addr_i, reg_wdata_i, v;
  logic [7:0] reg_rdata_o, treble_gain_bits_o, bass_gain_bits_o, headroom_bits_o;
  logic [15:0] treble_corner_value_o, bass_corner_value_o;
  logic [23:0] decoded_frame_counter_o;
  logic decode_run_o, aux_payload_ready_o;
  int failures = 0, checks = 0, cyc = 0;
  dtr_host_model host_u (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
    .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
  dtr_regs #(.AUX_BYTES(DTR_AUX_BYTES), .FW_CODE(FW_TB)) dut_u (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .sw_rst_i(sw_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .boot_done_i(boot_done_i), .avg_rate_bits_i(avg_rate_bits_i),
    .frame_decoded_i(frame_decoded_i), .aux_valid_i(aux_valid_i), .aux_data_i(aux_data_i),
    .aux_frame_end_i(aux_frame_end_i), .decode_run_o(decode_run_o),
    .treble_corner_value_o(treble_corner_value_o), .bass_corner_value_o(bass_corner_value_o),
    .treble_gain_bits_o(treble_gain_bits_o), .bass_gain_bits_o(bass_gain_bits_o),
    .headroom_bits_o(headroom_bits_o), .aux_payload_ready_o(aux_payload_ready_o),
    .decoded_frame_counter_o(decoded_frame_counter_o));
  // Clock and hang ceiling
  initial
  begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reset values, unmapped holes and version before boot
  task automatic t_reset();
    for (int a = 'h67; a <= 'hb6; a++)
    begin
      host_u.rd(8'(a), v);
      `CHK(v, DTR_RST_VAL)
    end
    $display("test reset end");
  endtask
  // Headroom first, corners and gains, run last
  task automatic t_tone();
    logic [7:0] val [7] = '{8'h0c, 8'hb8, 8'h0b, 8'hc8, 8'h00, 8'h0c, 8'hf4};
    logic [7:0] adr [7] = '{DTR_OFF_HEADROOM, DTR_OFF_TREB_LO, DTR_OFF_TREB_HI,
      DTR_OFF_BASS_LO, DTR_OFF_BASS_HI, DTR_OFF_TREB_GAIN, DTR_OFF_BASS_GAIN};
    foreach (adr[i])
      host_u.wr(adr[i], val[i]);
    host_u.wr(DTR_OFF_RUN, 8'h01);
    #1;
    `CHK(decode_run_o, 1'b1)
    `CHK(treble_corner_value_o, 16'h0bb8)
    `CHK(bass_corner_value_o, 16'h00c8)
    `CHK({treble_gain_bits_o, bass_gain_bits_o}, {DTR_GAIN_MAX, DTR_GAIN_MIN})
    `CHK(headroom_bits_o, 8'h0c)
    foreach (adr[i])
    begin
      host_u.rd(adr[i], v);
      `CHK(v, val[i])
    end
    $display("test tone end");
  endtask
  // Read-only status, refused writes, unmapped read
  task automatic t_status();
    @(posedge clk_sys_i);
    boot_done_i <= 1'b1;
    avg_rate_bits_i <= 8'd128;
    host_u.wr(DTR_OFF_AVG_RATE, 8'h11);
    host_u.wr(DTR_OFF_FW_VER, 8'h22);
    host_u.rd(DTR_OFF_AVG_RATE, v);
    `CHK(v, 8'd128)
    host_u.rd(DTR_OFF_FW_VER, v);
    `CHK(v, FW_TB)
    host_u.rd(8'h50, v);
    `CHK(v, 8'h00)
    $display("test status end");
  endtask
  // One byte past the buffer, then flag timing, burst read and clear
  task automatic t_aux();
    for (int k = 0; k <= DTR_AUX_BYTES; k++)
    begin
      @(posedge clk_sys_i);
      aux_valid_i <= 1'b1;
      aux_data_i <= 8'(k) ^ 8'ha5;
    end
    @(posedge clk_sys_i);
    aux_valid_i <= 1'b0;
    aux_frame_end_i <= 1'b1;
    frame_decoded_i <= 1'b1;
    @(posedge clk_sys_i);
    aux_frame_end_i <= 1'b0;
    frame_decoded_i <= 1'b0;
    #1;
    `CHK(aux_payload_ready_o, 1'b0)
    @(posedge clk_sys_i);
    #1;
    `CHK(aux_payload_ready_o, 1'b1)
    for (int k = 0; k < DTR_AUX_BYTES; k++)
    begin
      host_u.rd(DTR_OFF_AUX_FIRST + 8'(k), v);
      `CHK(v, 8'(k) ^ 8'ha5)
    end
    host_u.rd(DTR_OFF_FRAME_L, v);
    `CHK(v, 8'h01)
    // Bit count lives outside this bank, so it reads as a hole here
    host_u.rd(8'h41, v);
    `CHK(v, 8'h00)
    host_u.wr(DTR_OFF_AUX_FIRST, 8'h00);
    host_u.wr(DTR_OFF_AUX_READY, 8'h01);
    host_u.rd(DTR_OFF_AUX_FIRST, v);
    `CHK(v, 8'ha5)
    host_u.rd(DTR_OFF_AUX_READY, v);
    `CHK(v, 8'h01)
    // Frame done lands in the clearing cycle: the set must win
    fork
      begin
        @(posedge clk_sys_i);
        host_u.wr(DTR_OFF_AUX_READY, 8'h00);
      end
      begin
        @(posedge clk_sys_i);
        aux_frame_end_i <= 1'b1;
        @(posedge clk_sys_i);
        aux_frame_end_i <= 1'b0;
      end
    join
    host_u.rd(DTR_OFF_AUX_READY, v);
    `CHK(v, 8'h01)
    host_u.wr(DTR_OFF_AUX_READY, 8'h00);
    host_u.rd(DTR_OFF_AUX_READY, v);
    `CHK(v, 8'h00)
    $display("test aux end");
  endtask
  // Frame counting, then software reset mid-run
  task automatic t_count();
    repeat (3)
    begin
      @(posedge clk_sys_i);
      frame_decoded_i <= 1'b1;
      @(posedge clk_sys_i);
      frame_decoded_i <= 1'b0;
    end
    host_u.rd(DTR_OFF_FRAME_L, v);
    `CHK(v, 8'h04)
    @(posedge clk_sys_i);
    sw_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    sw_rst_i <= 1'b0;
    #1;
    `CHK({decode_run_o, decoded_frame_counter_o, headroom_bits_o}, 33'h0)
    host_u.rd(DTR_OFF_FW_VER, v);
    `CHK(v, FW_TB)
    $display("test count end");
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_reset();
    t_tone();
    t_status();
    t_aux();
    t_count();
    end_sim();
  end
endmodule

// ===== dv/dtr_host_model.sv
// Control-bus host model issuing register byte writes and reads
`timescale 1ns/1ns
module dtr_host_model (
  // Clock
  input  wire logic       clk_sys_i,
  // Register byte port
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  // Bus starts idle with no strobe
  initial
  begin
    reg_addr_o = 8'hff;
    reg_wdata_o = 8'hff;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One write strobe, then address and data go inverted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  // One read strobe, data taken once the registered answer lands
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    v = reg_rdata_i;
  endtask
endmodule

// ===== dv/dtr_regs_asserts.sv
// Concurrent checks on the tone and ancillary register bank ports
`timescale 1ns/1ns
module dtr_regs_asserts
  import dtr_pkg::*;
(
  // Clock and resets
  input wire logic        clk_sys_i,
  input wire logic        nrst_i,
  input wire logic        sw_rst_i,
  // Register writes and core events
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        frame_decoded_i,
  input wire logic        aux_frame_end_i,
  // Bank outputs
  input wire logic        decode_run_o,
  input wire logic [15:0] treble_corner_value_o,
  input wire logic [15:0] bass_corner_value_o,
  input wire logic [7:0]  treble_gain_bits_o,
  input wire logic        aux_payload_ready_o,
  input wire logic [23:0] decoded_frame_counter_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  // Write accepted outside software reset
  logic wr_ok;
  assign wr_ok = reg_wr_i && !sw_rst_i;
  a_run_write: assert property (wr_ok && reg_addr_i == DTR_OFF_RUN
    |=> decode_run_o == $past(reg_wdata_i[0])) else $error("run bit wrong");
  a_treb_low: assert property (wr_ok && reg_addr_i == DTR_OFF_TREB_LO
    |=> treble_corner_value_o[7:0] == $past(reg_wdata_i)) else $error("treble low wrong");
  a_bass_high: assert property (wr_ok && reg_addr_i == DTR_OFF_BASS_HI
    |=> bass_corner_value_o[15:8] == $past(reg_wdata_i)) else $error("bass high wrong");
  a_treb_gain: assert property (wr_ok && reg_addr_i == DTR_OFF_TREB_GAIN
    |=> treble_gain_bits_o == $past(reg_wdata_i)) else $error("treble gain wrong");
  a_ready_set: assert property ((aux_frame_end_i && !sw_rst_i) ##1 !sw_rst_i
    |=> aux_payload_ready_o) else $error("ready not set");
  a_ready_rise: assert property ($rose(aux_payload_ready_o)
    |-> $past(aux_frame_end_i, 2)) else $error("ready rose early");
  a_count_step: assert property (frame_decoded_i && !sw_rst_i
    |=> decoded_frame_counter_o == $past(decoded_frame_counter_o) + 24'h1)
    else $error("frame count step wrong");
  a_sw_clear: assert property (sw_rst_i
    |=> !decode_run_o && decoded_frame_counter_o == 24'h0 && treble_corner_value_o == 16'h0)
    else $error("soft reset missed");
endmodule
bind dtr_regs dtr_regs_asserts chk_u (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sw_rst_i(sw_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .frame_decoded_i(frame_decoded_i), .aux_frame_end_i(aux_frame_end_i),
  .decode_run_o(decode_run_o), .treble_corner_value_o(treble_corner_value_o),
  .bass_corner_value_o(bass_corner_value_o), .treble_gain_bits_o(treble_gain_bits_o),
  .aux_payload_ready_o(aux_payload_ready_o),
  .decoded_frame_counter_o(decoded_frame_counter_o)
);

// ===== rtl/dtr_aux_if.sv
// Interface carrying ancillary buffer writes from the fill sequencer to the bank
`timescale 1ns/1ns
interface dtr_aux_if;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic       frame_done;
  modport seq  (output wr_en, output wr_idx, output wr_data, output frame_done);
  modport bank (input wr_en, input wr_idx, input wr_data, input frame_done);
endinterface

// ===== rtl/dtr_aux_seq.sv
// Sequencer that writes one frame of ancillary bytes in ascending order
`timescale 1ns/1ns
module dtr_aux_seq
  import dtr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic sw_rst_i,
  // Core byte stream
  input  wire logic       byte_valid_i,
  input  wire logic [7:0] byte_data_i,
  input  wire logic       frame_end_i,
  // Buffer write port
  dtr_aux_if.seq          aux
);
  dtr_aux_state_t state_q;
  logic [5:0]     idx_q;

  // ==========================================
  // Fill sequence
  // Index advances one slot per byte, stopping at DTR_AUX_BYTES, one past the last slot
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= DTR_AUX_IDLE;
      idx_q   <= 6'h00;
    end
    else if (sw_rst_i)
    begin
      state_q <= DTR_AUX_IDLE;
      idx_q   <= 6'h00;
    end
    else
    begin
      case (state_q)
        DTR_AUX_IDLE:
        begin
          idx_q <= 6'h00;
          if (byte_valid_i)
          begin
            idx_q   <= 6'h01;
            state_q <= frame_end_i ? DTR_AUX_DONE : DTR_AUX_FILL;
          end
          else if (frame_end_i)
            state_q <= DTR_AUX_DONE;
        end
        DTR_AUX_FILL:
        begin
          if (byte_valid_i && idx_q != 6'(DTR_AUX_BYTES))
            idx_q <= idx_q + 6'h01;
          if (frame_end_i)
            state_q <= DTR_AUX_DONE;
        end
        DTR_AUX_DONE:
        begin
          idx_q   <= 6'h00;
          state_q <= DTR_AUX_IDLE;
        end
        default:
          state_q <= DTR_AUX_IDLE;
      endcase
    end
  end

  // Write strobe for the byte at the current slot
  assign aux.wr_en      = byte_valid_i && state_q != DTR_AUX_DONE
                          && idx_q != 6'(DTR_AUX_BYTES);
  assign aux.wr_idx     = (state_q == DTR_AUX_IDLE) ? 6'h00 : idx_q;
  assign aux.wr_data    = byte_data_i;
  // Done for the one cycle after frame end, even when bytes past the last slot were dropped
  assign aux.frame_done = (state_q == DTR_AUX_DONE);
endmodule

// ===== rtl/dtr_pkg.sv
// Package of register offsets, reset values and sizes for the tone and ancillary register bank
package dtr_pkg;
  localparam logic [7:0] DTR_OFF_AVG_RATE   = 8'h6a;
  localparam logic [7:0] DTR_OFF_FRAME_L    = 8'h67;
  localparam logic [7:0] DTR_OFF_FRAME_M    = 8'h68;
  localparam logic [7:0] DTR_OFF_FRAME_H    = 8'h69;
  localparam logic [7:0] DTR_OFF_FW_VER     = 8'h71;
  localparam logic [7:0] DTR_OFF_RUN        = 8'h72;
  localparam logic [7:0] DTR_OFF_TREB_LO    = 8'h77;
  localparam logic [7:0] DTR_OFF_TREB_HI    = 8'h78;
  localparam logic [7:0] DTR_OFF_BASS_LO    = 8'h79;
  localparam logic [7:0] DTR_OFF_BASS_HI    = 8'h7a;
  localparam logic [7:0] DTR_OFF_TREB_GAIN  = 8'h7b;
  localparam logic [7:0] DTR_OFF_BASS_GAIN  = 8'h7c;
  localparam logic [7:0] DTR_OFF_HEADROOM   = 8'h7d;
  localparam logic [7:0] DTR_OFF_AUX_FIRST  = 8'h7e;
  localparam logic [7:0] DTR_OFF_AUX_LAST   = 8'hb5;
  localparam logic [7:0] DTR_OFF_AUX_READY  = 8'hb6;
  localparam logic [7:0] DTR_RST_VAL        = 8'h00;
  localparam int         DTR_AUX_BYTES      = 56;
  localparam int         DTR_RUN_BIT        = 0;
  localparam int         DTR_READY_BIT      = 0;
  localparam logic [7:0] DTR_GAIN_MAX       = 8'h0c;
  localparam logic [7:0] DTR_GAIN_MIN       = 8'hf4;
  localparam logic [7:0] DTR_FW_CODE_DFLT   = 8'h5a;
  typedef enum logic [2:0] {
    DTR_AUX_IDLE  = 3'b001,
    DTR_AUX_FILL  = 3'b010,
    DTR_AUX_DONE  = 3'b100
  } dtr_aux_state_t;
endpackage

// ===== rtl/dtr_regs.sv
// Tone control and ancillary data register bank on the control-bus byte port
//
// Behaviour
// - Read-only average bitrate in kbit/s
// - Read-only firmware version after boot
// - Run bit starts decoding, reset clears
// - Treble corner joined high over low
// - Bass corner joined high over low
// - Treble gain signed, 1.5 dB steps
// - Bass gain signed, +-18 dB span
// - Headroom attenuates 1.5 dB per unit
// - 56 read-only ancillary bytes, contiguous
// - Ancillary bytes written ascending order
// - Ready flag shows new ancillary block
// - 24-bit frame counter per decoded frame
`timescale 1ns/1ns
module dtr_regs
  import dtr_pkg::*;
#(
  parameter int         AUX_BYTES = DTR_AUX_BYTES,
  parameter logic [7:0] FW_CODE   = DTR_FW_CODE_DFLT  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic        sw_rst_i,
  // Register byte port from the control-bus slave
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // Decoder core status
  input  wire logic        boot_done_i,
  input  wire logic [7:0]  avg_rate_bits_i,
  input  wire logic        frame_decoded_i,
  // Ancillary byte stream from the core
  input  wire logic        aux_valid_i,
  input  wire logic [7:0]  aux_data_i,
  input  wire logic        aux_frame_end_i,
  // Tone settings to the filter path, run flag, ready flag and frame count
  output logic             decode_run_o,
  output logic [15:0]      treble_corner_value_o,
  output logic [15:0]      bass_corner_value_o,
  output logic [7:0]       treble_gain_bits_o,
  output logic [7:0]       bass_gain_bits_o,
  output logic [7:0]       headroom_bits_o,
  output logic             aux_payload_ready_o,
  output logic [23:0]      decoded_frame_counter_o
);
  // Elaboration check: the buffer window is fixed by the address map
  if (AUX_BYTES != DTR_AUX_BYTES)
  begin : g_bad_aux_bytes
    $error("AUX_BYTES must match the ancillary window size");
  end

  dtr_aux_if aux ();

  logic [7:0]  avg_q;
  logic [7:0]  fw_q;
  logic        run_q;
  logic [7:0]  treb_lo_q;
  logic [7:0]  treb_hi_q;
  logic [7:0]  bass_lo_q;
  logic [7:0]  bass_hi_q;
  logic [7:0]  treb_gain_q;
  logic [7:0]  bass_gain_q;
  logic [7:0]  head_q;
  logic        ready_q;
  logic [23:0] frame_q;
  logic [7:0]  rdata_q;
  logic [7:0]  aux_mem [AUX_BYTES];
  logic [7:0]  aux_off;
  logic [7:0]  rdata_d;
  logic        in_aux;
  logic        wr_run;
  logic        wr_treb_lo;
  logic        wr_treb_hi;
  logic        wr_bass_lo;
  logic        wr_bass_hi;
  logic        wr_treb_gain;
  logic        wr_bass_gain;
  logic        wr_head;
  logic        wr_ready_clr;

  // ==========================================
  // Fill sequencer
  dtr_aux_seq u_seq (
    .clk_sys_i    (clk_sys_i),
    .nrst_i       (nrst_i),
    .sw_rst_i     (sw_rst_i),
    .byte_valid_i (aux_valid_i),
    .byte_data_i  (aux_data_i),
    .frame_end_i  (aux_frame_end_i),
    .aux          (aux.seq)
  );

  // ==========================================
  // Status registers
  // Average bitrate sampled from the core; firmware code loaded from FW_CODE once boot is done
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      avg_q <= DTR_RST_VAL;
      fw_q  <= DTR_RST_VAL;
    end
    else if (sw_rst_i)
    begin
      avg_q <= DTR_RST_VAL;
    end
    else
    begin
      avg_q <= avg_rate_bits_i;
      if (boot_done_i)
        fw_q <= FW_CODE;
    end
  end

  // Frame counter, one step per decoded frame
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      frame_q <= 24'h000000;
    else if (sw_rst_i)
      frame_q <= 24'h000000;
    else if (frame_decoded_i)
      frame_q <= frame_q + 24'h000001;
  end

  // ==========================================
  // Write decode
  // One strobe per writable byte; writes to read-only or unmapped bytes fall away
  assign wr_run       = reg_wr_i && (reg_addr_i == DTR_OFF_RUN);
  assign wr_treb_lo   = reg_wr_i && (reg_addr_i == DTR_OFF_TREB_LO);
  assign wr_treb_hi   = reg_wr_i && (reg_addr_i == DTR_OFF_TREB_HI);
  assign wr_bass_lo   = reg_wr_i && (reg_addr_i == DTR_OFF_BASS_LO);
  assign wr_bass_hi   = reg_wr_i && (reg_addr_i == DTR_OFF_BASS_HI);
  assign wr_treb_gain = reg_wr_i && (reg_addr_i == DTR_OFF_TREB_GAIN);
  assign wr_bass_gain = reg_wr_i && (reg_addr_i == DTR_OFF_BASS_GAIN);
  assign wr_head      = reg_wr_i && (reg_addr_i == DTR_OFF_HEADROOM);
  assign wr_ready_clr = reg_wr_i && (reg_addr_i == DTR_OFF_AUX_READY)
                        && !reg_wdata_i[DTR_READY_BIT];

  // ==========================================
  // Control registers
  // Run flag; the host sets it only once the tone fields are in place
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      run_q <= 1'b0;
    else if (sw_rst_i)
      run_q <= 1'b0;
    else if (wr_run)
      run_q <= reg_wdata_i[DTR_RUN_BIT];
  end

  // Corner frequency bytes, high over low, no shadowing between the halves
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      treb_lo_q <= DTR_RST_VAL;
      treb_hi_q <= DTR_RST_VAL;
      bass_lo_q <= DTR_RST_VAL;
      bass_hi_q <= DTR_RST_VAL;
    end
    else if (sw_rst_i)
    begin
      treb_lo_q <= DTR_RST_VAL;
      treb_hi_q <= DTR_RST_VAL;
      bass_lo_q <= DTR_RST_VAL;
      bass_hi_q <= DTR_RST_VAL;
    end
    else
    begin
      if (wr_treb_lo)
        treb_lo_q <= reg_wdata_i;
      if (wr_treb_hi)
        treb_hi_q <= reg_wdata_i;
      if (wr_bass_lo)
        bass_lo_q <= reg_wdata_i;
      if (wr_bass_hi)
        bass_hi_q <= reg_wdata_i;
    end
  end

  // Gain and headroom codes, held as written; keeping them in range is the host's job
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      treb_gain_q <= DTR_RST_VAL;
      bass_gain_q <= DTR_RST_VAL;
      head_q      <= DTR_RST_VAL;
    end
    else if (sw_rst_i)
    begin
      treb_gain_q <= DTR_RST_VAL;
      bass_gain_q <= DTR_RST_VAL;
      head_q      <= DTR_RST_VAL;
    end
    else
    begin
      if (wr_treb_gain)
        treb_gain_q <= reg_wdata_i;
      if (wr_bass_gain)
        bass_gain_q <= reg_wdata_i;
      if (wr_head)
        head_q <= reg_wdata_i;
    end
  end

  // ==========================================
  // Ancillary buffer and ready flag
  // Buffer bytes, written only by the sequencer
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < AUX_BYTES; i++)
        aux_mem[i] <= DTR_RST_VAL;
    end
    else if (sw_rst_i)
    begin
      for (int i = 0; i < AUX_BYTES; i++)
        aux_mem[i] <= DTR_RST_VAL;
    end
    else if (aux.wr_en)
      aux_mem[aux.wr_idx] <= aux.wr_data;
  end

  // Ready set on the sequencer's frame done, the cycle after frame end; a set in the clearing cycle wins
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ready_q <= 1'b0;
    else if (sw_rst_i)
      ready_q <= 1'b0;
    else if (aux.frame_done)
      ready_q <= 1'b1;
    else if (wr_ready_clr)
      ready_q <= 1'b0;
  end

  // ==========================================
  // Read path
  // Decode of the read address; unmapped bytes read zero
  assign in_aux  = (reg_addr_i >= DTR_OFF_AUX_FIRST) && (reg_addr_i <= DTR_OFF_AUX_LAST);
  assign aux_off = reg_addr_i - DTR_OFF_AUX_FIRST;

  always_comb
  begin
    rdata_d = 8'h00;
    if (in_aux)
      rdata_d = aux_mem[aux_off[5:0]];
    else
    begin
      case (reg_addr_i)
        DTR_OFF_AVG_RATE:  rdata_d = avg_q;
        DTR_OFF_FW_VER:    rdata_d = fw_q;
        DTR_OFF_RUN:       rdata_d = {7'h00, run_q};
        DTR_OFF_TREB_LO:   rdata_d = treb_lo_q;
        DTR_OFF_TREB_HI:   rdata_d = treb_hi_q;
        DTR_OFF_BASS_LO:   rdata_d = bass_lo_q;
        DTR_OFF_BASS_HI:   rdata_d = bass_hi_q;
        DTR_OFF_TREB_GAIN: rdata_d = treb_gain_q;
        DTR_OFF_BASS_GAIN: rdata_d = bass_gain_q;
        DTR_OFF_HEADROOM:  rdata_d = head_q;
        DTR_OFF_AUX_READY: rdata_d = {7'h00, ready_q};
        DTR_OFF_FRAME_L:   rdata_d = frame_q[7:0];
        DTR_OFF_FRAME_M:   rdata_d = frame_q[15:8];
        DTR_OFF_FRAME_H:   rdata_d = frame_q[23:16];
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // Registered read data, updated on each read strobe
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_q <= 8'h00;
    else if (reg_rd_i)
      rdata_q <= rdata_d;
  end

  // ==========================================
  // Outputs, all straight from flip-flops
  assign reg_rdata_o             = rdata_q;
  assign decode_run_o            = run_q;
  assign treble_corner_value_o   = {treb_hi_q, treb_lo_q};
  assign bass_corner_value_o     = {bass_hi_q, bass_lo_q};
  assign treble_gain_bits_o      = treb_gain_q;
  assign bass_gain_bits_o        = bass_gain_q;
  assign headroom_bits_o         = head_q;
  assign aux_payload_ready_o     = ready_q;
  assign decoded_frame_counter_o = frame_q;
endmodule
